// ==== core/fbid_decoder.sv ====
// Operation
// - Every instruction is one 14-bit word: opcode plus operand fields.
// - Classify into byte, bit, or literal and control groups.
// - Destination flag 0 writes accumulator, 1 writes file register.
// - Register operand is seven bits, addressing 0x00 to 0x7F.
// - Bit position field selects one bit of the addressed 8-bit register.
// - Literals are 8 bits for data, 11 bits for program addresses.
// - One instruction cycle is four oscillator periods; ordinary ops take one.
// - Taken skip or program counter change takes two cycles, second a no-op.
// - Any file register instruction reads it first, then writes.
// - Clearing the port register reads it and clears pending pin mismatch.
// - Don't-care bits are ignored whatever their value.
// - Port self-update reads the pin levels, not the output latch.
// - Writing timer zero count with result to file clears its prescaler.
`timescale 1ns/100ps
`include "fbid_consts.svh"
module fbid_decoder
    import fbid_pkg::*;
(
    input  wire logic        CORE_CLK,
    input  wire logic        RSTN,
    input  wire logic [13:0] INSN,
    input  wire logic        SKIP_TRUE,
    input  wire logic        PRESCALER_ON_TIMER,
    output logic      [1:0]  QPHASE,
    output logic             CYCLE_END,
    output logic      [1:0]  CATEGORY,
    output logic      [6:0]  FILE_ADDR,
    output logic             DEST_FILE,
    output logic      [2:0]  BIT_POS,
    output logic      [7:0]  LIT8,
    output logic      [10:0] LIT11,
    output logic             FILE_RD,
    output logic             FILE_WR,
    output logic             ACC_WR,
    output logic             PORT_FROM_PINS,
    output logic             PORT_MISMATCH_CLR,
    output logic             PRESCALER_CLR,
    output logic             IS_NOP
);

    // ****************************************
    // Helper functions
    // ****************************************

    // True when the word touches a file register (byte or bit group)
    function automatic logic uses_file(input logic [13:0] w);
        logic [3:0] s;
        s = w[`FBID_SUB_HI:`FBID_SUB_LO];
        if (w[`FBID_CAT_HI:`FBID_CAT_LO] == `FBID_CAT_BIT) begin
            uses_file = 1'b1;
        end else if (w[`FBID_CAT_HI:`FBID_CAT_LO] != `FBID_CAT_BYTE) begin
            uses_file = 1'b0;
        end else if (s == `FBID_SUB_MISC) begin
            uses_file = w[`FBID_DEST_BIT]; // Store to file form only
        end else if (s == `FBID_SUB_CLR) begin
            uses_file = w[`FBID_DEST_BIT]; // Clear W form has no file
        end else begin
            uses_file = 1'b1;
        end
    endfunction : uses_file

    // True when the word alters the program counter
    function automatic logic changes_pc(input logic [13:0] w);
        if (w[`FBID_CAT_HI:`FBID_CAT_LO] == `FBID_CAT_JUMP) begin
            changes_pc = 1'b1;
        end else if (w[`FBID_CAT_HI:`FBID_CAT_LO] == `FBID_CAT_LIT) begin
            changes_pc = (w[11:10] == `FBID_LSUB_RETLW);
        end else begin
            changes_pc = (w == `FBID_OP_RETURN) || (w == `FBID_OP_RETFIE);
        end
    endfunction : changes_pc

    // True when the word is a conditional skip
    function automatic logic is_skip(input logic [13:0] w);
        logic [1:0] c;
        c = w[`FBID_CAT_HI:`FBID_CAT_LO];
        if (c == `FBID_CAT_BYTE) begin
            is_skip = (w[`FBID_SUB_HI:`FBID_SUB_LO] == `FBID_SUB_DECSZ) ||
                      (w[`FBID_SUB_HI:`FBID_SUB_LO] == `FBID_SUB_INCSZ);
        end else if (c == `FBID_CAT_BIT) begin
            is_skip = (w[11:10] == `FBID_BSUB_TSTC) || (w[11:10] == `FBID_BSUB_TSTS);
        end else begin
            is_skip = 1'b0;
        end
    endfunction : is_skip

    // ****************************************
    // Oscillator phase divider
    // ****************************************
    logic [1:0]  qcnt_r;
    logic [1:0]  qcnt_nxt;
    logic        cyc_end_r;
    logic        cyc_end_nxt;

    // Four oscillator periods make one instruction cycle
    always_comb begin
        qcnt_nxt    = qcnt_r + 2'h1;
        cyc_end_nxt = (qcnt_r == (`FBID_QLAST - 2'h1));
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            qcnt_r    <= 2'h0;
            cyc_end_r <= 1'b0;
        end else begin
            qcnt_r    <= qcnt_nxt;
            cyc_end_r <= cyc_end_nxt;
        end
    end

    // ****************************************
    // Field extraction and sequencing
    // ****************************************
    fbid_state_t st_r;
    fbid_state_t st_nxt;
    logic [1:0]  cat_r,  cat_nxt;
    logic [6:0]  fa_r,   fa_nxt;
    logic        dst_r,  dst_nxt;
    logic [2:0]  bp_r,   bp_nxt;
    logic [7:0]  k8_r,   k8_nxt;
    logic [10:0] k11_r,  k11_nxt;
    logic        rd_r,   rd_nxt;
    logic        wr_r,   wr_nxt;
    logic        aw_r,   aw_nxt;
    logic        pin_r,  pin_nxt;
    logic        mm_r,   mm_nxt;
    logic        ps_r,   ps_nxt;
    logic        nop_r,  nop_nxt;

    // Decode is latched once per instruction cycle; the word is taken at the
    // last phase so the program memory has the whole cycle to present it.
    always_comb begin
        logic [1:0] c;
        logic       fu;
        logic       wrf;
        c       = INSN[`FBID_CAT_HI:`FBID_CAT_LO];
        fu      = uses_file(INSN);
        wrf     = 1'b0;
        st_nxt  = st_r;
        cat_nxt = cat_r;
        fa_nxt  = fa_r;
        dst_nxt = dst_r;
        bp_nxt  = bp_r;
        k8_nxt  = k8_r;
        k11_nxt = k11_r;
        rd_nxt  = rd_r;
        wr_nxt  = wr_r;
        aw_nxt  = aw_r;
        pin_nxt = pin_r;
        mm_nxt  = mm_r;
        ps_nxt  = ps_r;
        nop_nxt = nop_r;
        if (qcnt_r == `FBID_QLAST) begin
            case (st_r)
                FBID_FLUSH: begin
                    // Second cycle of a two-cycle op runs as a no-op
                    st_nxt  = FBID_EXEC;
                    nop_nxt = 1'b1;
                    rd_nxt  = 1'b0;
                    wr_nxt  = 1'b0;
                    aw_nxt  = 1'b0;
                    pin_nxt = 1'b0;
                    mm_nxt  = 1'b0;
                    ps_nxt  = 1'b0;
                end
                default: begin
                    // Skip outcome is only known for the word in hand
                    if (changes_pc(INSN) || (is_skip(INSN) && SKIP_TRUE)) begin
                        st_nxt = FBID_FLUSH;
                    end else begin
                        st_nxt = FBID_EXEC;
                    end
                    if (c == `FBID_CAT_BYTE) begin
                        cat_nxt = FBID_BYTE_OP;
                    end else if (c == `FBID_CAT_BIT) begin
                        cat_nxt = FBID_BIT_OP;
                    end else begin
                        cat_nxt = FBID_LIT_OP;
                    end
                    fa_nxt  = INSN[`FBID_FADDR_HI:0];
                    bp_nxt  = INSN[`FBID_BITPOS_HI:`FBID_BITPOS_LO];
                    k8_nxt  = INSN[`FBID_K8_HI:0];
                    k11_nxt = INSN[`FBID_K11_HI:0];
                    // Bit ops other than tests write back; byte ops obey d
                    if (c == `FBID_CAT_BIT) begin
                        wrf = !INSN[11];
                    end else if (c == `FBID_CAT_BYTE) begin
                        wrf = fu && INSN[`FBID_DEST_BIT];
                    end else begin
                        wrf = 1'b0;
                    end
                    dst_nxt = wrf;
                    rd_nxt  = fu;
                    wr_nxt  = wrf;
                    // Byte results with d clear land in the accumulator
                    aw_nxt  = (c == `FBID_CAT_BYTE) && !INSN[`FBID_DEST_BIT] &&
                              (INSN[`FBID_SUB_HI:`FBID_SUB_LO] != `FBID_SUB_MISC)
                              || (c == `FBID_CAT_LIT);
                    // Reads of the port see pins, which drops the mismatch
                    pin_nxt = fu && (INSN[`FBID_FADDR_HI:0] == `FBID_ADDR_PORT);
                    mm_nxt  = fu && (INSN[`FBID_FADDR_HI:0] == `FBID_ADDR_PORT);
                    ps_nxt  = wrf && PRESCALER_ON_TIMER &&
                              (INSN[`FBID_FADDR_HI:0] == `FBID_ADDR_TMR);
                    // Plain no-op ignores its don't-care bits 5 and 6
                    nop_nxt = (INSN[13:7] == 7'h00) && (INSN[4:0] == 5'h00);
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            st_r  <= FBID_EXEC;
            cat_r <= 2'h0;
            fa_r  <= 7'h00;
            dst_r <= 1'b0;
            bp_r  <= 3'h0;
            k8_r  <= 8'h00;
            k11_r <= 11'h000;
            rd_r  <= 1'b0;
            wr_r  <= 1'b0;
            aw_r  <= 1'b0;
            pin_r <= 1'b0;
            mm_r  <= 1'b0;
            ps_r  <= 1'b0;
            nop_r <= 1'b1;
        end else begin
            st_r  <= st_nxt;
            cat_r <= cat_nxt;
            fa_r  <= fa_nxt;
            dst_r <= dst_nxt;
            bp_r  <= bp_nxt;
            k8_r  <= k8_nxt;
            k11_r <= k11_nxt;
            rd_r  <= rd_nxt;
            wr_r  <= wr_nxt;
            aw_r  <= aw_nxt;
            pin_r <= pin_nxt;
            mm_r  <= mm_nxt;
            ps_r  <= ps_nxt;
            nop_r <= nop_nxt;
        end
    end

    // Outputs straight from flops
    assign QPHASE            = qcnt_r;
    assign CYCLE_END         = cyc_end_r;
    assign CATEGORY          = cat_r;
    assign FILE_ADDR         = fa_r;
    assign DEST_FILE         = dst_r;
    assign BIT_POS           = bp_r;
    assign LIT8              = k8_r;
    assign LIT11             = k11_r;
    assign FILE_RD           = rd_r;
    assign FILE_WR           = wr_r;
    assign ACC_WR            = aw_r;
    assign PORT_FROM_PINS    = pin_r;
    assign PORT_MISMATCH_CLR = mm_r;
    assign PRESCALER_CLR     = ps_r;
    assign IS_NOP            = nop_r;

    // ****************************************
    // Checks
    // ****************************************
    property p_cycle_four;
        @(posedge CORE_CLK) disable iff (!RSTN) CYCLE_END |=> !CYCLE_END [*3] ##1 CYCLE_END;
    endproperty
    a_cycle_four: assert property (p_cycle_four) else $error("Cycle not four");

    property p_write_reads;
        @(posedge CORE_CLK) disable iff (!RSTN) FILE_WR |-> FILE_RD;
    endproperty
    a_write_reads: assert property (p_write_reads) else $error("Write without read");

    property p_dest;
        @(posedge CORE_CLK) disable iff (!RSTN)
            (CATEGORY == FBID_BYTE_OP && FILE_WR) |-> DEST_FILE && !ACC_WR;
    endproperty
    a_dest: assert property (p_dest) else $error("Destination wrong");

    property p_flush;
        @(posedge CORE_CLK) disable iff (!RSTN)
            (qcnt_r == `FBID_QLAST && st_r == FBID_EXEC && INSN[13:12] == `FBID_CAT_JUMP)
            |=> ##4 IS_NOP && !FILE_WR;
    endproperty
    a_flush: assert property (p_flush) else $error("No second no-op cycle");

    property p_port_clr;
        @(posedge CORE_CLK) disable iff (!RSTN)
            PORT_MISMATCH_CLR |-> FILE_RD && FILE_ADDR == `FBID_ADDR_PORT && PORT_FROM_PINS;
    endproperty
    a_port_clr: assert property (p_port_clr) else $error("Port clear bad");

    property p_presc;
        @(posedge CORE_CLK) disable iff (!RSTN)
            PRESCALER_CLR |-> FILE_WR && FILE_ADDR == `FBID_ADDR_TMR;
    endproperty
    a_presc: assert property (p_presc) else $error("Prescaler clear bad");

    property p_stable;
        @(posedge CORE_CLK) disable iff (!RSTN)
            (qcnt_r != `FBID_QLAST) |=> $stable(FILE_ADDR) && $stable(CATEGORY);
    endproperty
    a_stable: assert property (p_stable) else $error("Fields moved mid cycle");

    property p_nop_dontcare;
        @(posedge CORE_CLK) disable iff (!RSTN)
            (qcnt_r == `FBID_QLAST && st_r == FBID_EXEC && INSN == 14'h0060) |=> IS_NOP;
    endproperty
    a_nop_dontcare: assert property (p_nop_dontcare) else $error("Don't care not ignored");

endmodule : fbid_decoder

// ==== core/fbid_consts.svh ====
`ifndef FBID_CONSTS_SVH
`define FBID_CONSTS_SVH
// Instruction word geometry
`define FBID_IW_W        14
`define FBID_CAT_HI      13
`define FBID_CAT_LO      12
`define FBID_DEST_BIT    7
`define FBID_FADDR_HI    6
`define FBID_BITPOS_HI   9
`define FBID_BITPOS_LO   7
`define FBID_K8_HI       7
`define FBID_K11_HI      10
`define FBID_SUB_HI      11
`define FBID_SUB_LO      8
// Category codes in the two top bits
`define FBID_CAT_BYTE    2'h0
`define FBID_CAT_BIT     2'h1
`define FBID_CAT_JUMP    2'h2
`define FBID_CAT_LIT     2'h3
// Byte op sub-codes with special meaning
`define FBID_SUB_MISC    4'h0
`define FBID_SUB_CLR     4'h1
`define FBID_SUB_DECSZ   4'hb
`define FBID_SUB_INCSZ   4'hf
// Bit op sub-codes
`define FBID_BSUB_TSTC   2'h2
`define FBID_BSUB_TSTS   2'h3
// Control words with no operand
`define FBID_OP_RETURN   14'h0008
`define FBID_OP_RETFIE   14'h0009
`define FBID_OP_SLEEP    14'h0063
`define FBID_OP_WDCLR    14'h0064
// Literal sub-codes that return
`define FBID_LSUB_RETLW  2'h1
// Special file addresses
`define FBID_ADDR_TMR    7'h01
`define FBID_ADDR_PORT   7'h05
// Oscillator periods per instruction cycle
`define FBID_QPHASES     4
`define FBID_QCNT_W      2
`define FBID_QLAST       2'h3
`endif

// ==== core/fbid_pkg.sv ====
package fbid_pkg;
    // Instruction categories
    typedef enum logic [1:0] {
        FBID_BYTE_OP = 2'b00,
        FBID_BIT_OP  = 2'b01,
        FBID_LIT_OP  = 2'b10
    } fbid_cat_t;
    // Execution state: normal cycle or forced no-op second cycle
    typedef enum logic [0:0] {
        FBID_EXEC  = 1'b0,
        FBID_FLUSH = 1'b1
    } fbid_state_t;
endpackage : fbid_pkg

// ==== sim/fbid_prog_model.sv ====
`timescale 1ns/100ps
module fbid_prog_model
    import fbid_pkg::*;
(
    input  wire logic [1:0]  qphase,
    input  wire logic [13:0] word_in,
    input  wire logic        skip_in,
    output logic      [13:0] insn,
    output logic             skip_true
);
    // ************************************************************
    // Program memory output
    // ************************************************************
    // Word valid only in the fetch phase; the inverse at other times
    // so a decoder that samples in the wrong phase gets a wrong word
    always_comb begin
        insn      = (qphase == 2'h3) ? word_in : ~word_in;
        skip_true = (qphase == 2'h3) ? skip_in : ~skip_in;
    end
endmodule : fbid_prog_model

// ==== sim/tb_fourteen_bit_insn_decoder.sv ====
`timescale 1ns/100ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module tb_fourteen_bit_insn_decoder;
    import fbid_pkg::*;
    // ************************************************************
    // Signals and instances
    // ************************************************************
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        psc_on = 1'b0;
    logic [13:0] word_in = 14'h0000;
    logic        skip_in = 1'b0;
    logic [13:0] insn;
    logic        skip_true;
    logic [1:0]  qphase, category;
    logic        cyc_end, dest, frd, fwr, awr, pins, mclr, pclr, nop;
    logic [6:0]  faddr;
    logic [2:0]  bpos;
    logic [7:0]  lit8;
    logic [10:0] lit11;
    int          fail_count = 0;
    int          comparisons = 0;

    fbid_prog_model pm (.qphase(qphase), .word_in(word_in), .skip_in(skip_in),
                        .insn(insn), .skip_true(skip_true));
    fbid_decoder dut (.CORE_CLK(clk), .RSTN(rstn), .INSN(insn), .SKIP_TRUE(skip_true),
        .PRESCALER_ON_TIMER(psc_on), .QPHASE(qphase), .CYCLE_END(cyc_end),
        .CATEGORY(category), .FILE_ADDR(faddr), .DEST_FILE(dest), .BIT_POS(bpos),
        .LIT8(lit8), .LIT11(lit11), .FILE_RD(frd), .FILE_WR(fwr), .ACC_WR(awr),
        .PORT_FROM_PINS(pins), .PORT_MISMATCH_CLR(mclr), .PRESCALER_CLR(pclr),
        .IS_NOP(nop));

    // 200 MHz core clock
    always #2.5 clk = ~clk;

    // ************************************************************
    // Shared tasks
    // ************************************************************
    // Present a word, let the fetch edge take it, return in phase 0
    task automatic issue(input logic [13:0] w, input logic sk);
        int n = 0;
        word_in = w;
        skip_in = sk;
        while (qphase !== 2'h3 && n < 8) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK("cycle_end", 1'b1, cyc_end)
        @(posedge clk);
        #1;
    endtask : issue

    task automatic wrap_up();
        if (fail_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    // ************************************************************
    // Scenarios
    // ************************************************************
    // Whole-register ops, both destinations, top address first
    task automatic t_byte();
        logic [3:0] subs [12] = '{4'h7, 4'h5, 4'h3, 4'h4, 4'h8, 4'hd,
                                  4'hc, 4'h2, 4'he, 4'h6, 4'ha, 4'h9};
        logic [6:0] f;
        for (int i = 0; i < 12; i++) begin
            f = 7'h7f - 7'(i * 9);
            issue({2'b00, subs[i], i[0], f}, 1'b0);
            `CHK("cat", 2'h0, category)
            `CHK("faddr", f, faddr)
            `CHK("dest", i[0], dest)
            `CHK("frd", 1'b1, frd)
            `CHK("fwr", i[0], fwr)
            `CHK("awr", ~i[0], awr)
        end
    endtask : t_byte

    // Bit clear at even and set at odd positions, covering every bit position
    task automatic t_bit();
        for (int b = 0; b < 8; b++) begin
            issue({3'b010, b[0], b[2:0], 7'h10 + 7'(b)}, 1'b0);
            `CHK("cat", 2'h1, category)
            `CHK("bpos", b[2:0], bpos)
            `CHK("faddr", 7'h10 + 7'(b), faddr)
            `CHK("frd", 1'b1, frd)
            `CHK("fwr", 1'b1, fwr)
        end
    endtask : t_bit

    // Data literal with every don't-care pattern, then idle and clear-acc forms
    task automatic t_lit();
        for (int i = 0; i < 4; i++) begin
            issue({4'b1100, i[1:0], 8'h5a ^ 8'(i)}, 1'b0);
            `CHK("cat", 2'h2, category)
            `CHK("lit8", 8'h5a ^ 8'(i), lit8)
            `CHK("awr", 1'b1, awr)
        end
        issue(14'h0060, 1'b0);
        `CHK("nop", 1'b1, nop)
        `CHK("fwr", 1'b0, fwr)
        issue(14'h017f, 1'b0);
        `CHK("awr", 1'b1, awr)
        `CHK("fwr", 1'b0, fwr)
    endtask : t_lit

    // Jump and call: address literal, then a forced idle cycle
    task automatic t_flow();
        for (int j = 0; j < 2; j++) begin
            issue({2'b10, j[0], 11'h7ff - 11'(j * 11'h2aa)}, 1'b0);
            `CHK("cat", 2'h2, category)
            `CHK("lit11", 11'h7ff - 11'(j * 11'h2aa), lit11)
            issue(14'h07ff, 1'b0);
            `CHK("nop", 1'b1, nop)
            `CHK("fwr", 1'b0, fwr)
            `CHK("frd", 1'b0, frd)
            issue(14'h07ff, 1'b0);
            `CHK("fwr", 1'b1, fwr)
        end
    endtask : t_flow

    // Plain return and return with literal, each followed by a forced idle cycle
    task automatic t_ret();
        issue(14'h0008, 1'b0);
        `CHK("nop", 1'b0, nop)
        `CHK("awr", 1'b0, awr)
        issue(14'h0785, 1'b0);
        `CHK("nop", 1'b1, nop)
        issue(14'h3655, 1'b0);
        `CHK("lit8", 8'h55, lit8)
        `CHK("awr", 1'b1, awr)
        issue(14'h0785, 1'b0);
        `CHK("nop", 1'b1, nop)
        `CHK("fwr", 1'b0, fwr)
    endtask : t_ret

    // Skip taken and not taken, then the following word
    task automatic t_skip();
        logic [13:0] w [4] = '{14'h0bc0, 14'h1dc0, 14'h0fc0, 14'h19c0};
        for (int j = 0; j < 4; j++) begin
            issue(w[j], ~j[0]);
            issue(14'h0785, 1'b0);
            `CHK("nop", ~j[0], nop)
            `CHK("fwr", j[0], fwr)
        end
    endtask : t_skip

    // Port clear, port self-update, and an ordinary address
    task automatic t_port();
        issue(14'h0185, 1'b0);
        `CHK("frd", 1'b1, frd)
        `CHK("mclr", 1'b1, mclr)
        issue(14'h0885, 1'b0);
        `CHK("pins", 1'b1, pins)
        issue(14'h0186, 1'b0);
        `CHK("mclr", 1'b0, mclr)
        `CHK("pins", 1'b0, pins)
    endtask : t_port

    // Timer count writes with and without the prescaler assigned
    task automatic t_timer();
        psc_on = 1'b1;
        issue(14'h0081, 1'b0);
        `CHK("pclr", 1'b1, pclr)
        issue(14'h0701, 1'b0);
        `CHK("pclr", 1'b0, pclr)
        psc_on = 1'b0;
        issue(14'h0081, 1'b0);
        `CHK("pclr", 1'b0, pclr)
    endtask : t_timer

    // Spacing between cycle-end pulses is four clocks
    task automatic t_phase();
        int n = 0;
        issue(14'h0000, 1'b0);
        while (cyc_end !== 1'b1 && n < 8) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK("period", 32'd3, 32'(n))
    endtask : t_phase

    // ************************************************************
    // Main sequence and watchdog
    // ************************************************************
    initial begin
        repeat (5) @(posedge clk);
        #1;
        `CHK("rst_nop", 1'b1, nop)
        `CHK("rst_phase", 2'h0, qphase)
        rstn = 1'b1;
        t_byte();
        t_bit();
        t_lit();
        t_flow();
        t_ret();
        t_skip();
        t_port();
        t_timer();
        t_phase();
        wrap_up();
    end

    // About 50 words of 4 clocks each; ample margin
    initial begin
        #5000;
        fail_count++;
        wrap_up();
    end
endmodule : tb_fourteen_bit_insn_decoder
